// file: hdl/sisq_top.sv
// Purpose: Settle delay, intensify, colour setup, wipe and done sequencer.
// Assumes: Status bits arrive as plain ports from the host side logic.
// Notes:   Returns from the scope are synchronised by three flip-flops.
// Notes on behaviour
// [R1] Normal settle: first one-shot, then fixed 3us.
// [R2] Fast intensify skips first one-shot.
// [R3] Software sets fast mode before intensify write.
// [R4] Rising red bit starts 300us setup timer.
// [R5] Setup end sets done, save, interrupt.
// [R6] Falling red bit starts 1.6ms green timer.
// [R7] Colour pulse clears done; ack clears interrupt.
// [R8] Green first stage 18us, total 21us.
// [R9] Green nonstore intensify pulse is 1us.
// [R10] Red first stage is 15us.
// [R11] Red intensify pulse lengthens to 6us.
// [R12] Channel bit passes straight to scope.
// [R13] Store bit lengthens intensify pulse to 6us.
// [R14] Wipe request clears when return goes low.
// [R15] Wipe return rising sets done and interrupt.
// [R16] Done rising with enable sets interrupt latch.
// [R17] Start strobe clears done; pulse sets it.
// [R18] Wipe request holds done clear until return.
// [R19] External settle end sets done again; here it starts the intensify pulse, and the pulse end sets done.
// [R20] Coordinate latches load 12 bits, clear on init.
// [R21] Mode bits select start strobe source.
// [R22] External delay mode waits for scope completion.
// [R23] One-shots are synchronous down-counters.
`timescale 1ns/100ps
module sisq_top
    import sisq_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               system_clear_n,
    input  wire logic [COORD_W-1:0] bus_data,
    input  wire logic               load_horiz,
    input  wire logic               load_vert,
    input  wire logic               status_write,
    input  wire logic               intensify_cmd,
    input  wire logic               fast_intensify,
    input  wire logic [1:0]         intensify_mode,
    input  wire logic               ext_delay,
    input  wire logic               int_enable,
    input  wire logic               red_mode,
    input  wire logic               channel_sel,
    input  wire logic               store_mode,
    input  wire logic               wipe_set,
    input  wire logic               wipe_return,
    input  wire logic               beam_settling_active,
    input  wire logic               interrupt_ack,
    output logic [COORD_W-1:0]      horiz_coord,
    output logic [COORD_W-1:0]      vert_coord,
    output logic                    intensify_out,
    output logic                    channel_out,
    output logic                    wipe_request,
    output logic                    done_flag,
    output logic                    save_latch,
    output logic                    interrupt_req,
    output logic                    start_delay_strobe,
    output logic                    colour_change_strobe
);
    // Synchroniser stages for the scope return lines.
    logic wret_s1_reg;
    logic wret_s2_reg;
    logic wret_s3_reg;
    logic busy_s1_reg;
    logic busy_s2_reg;
    logic busy_s3_reg;
    // Registered copies of the colour bit and coordinate latches.
    logic               red_reg;
    logic [COORD_W-1:0] horiz_reg;
    logic [COORD_W-1:0] vert_reg;
    // Flags.
    logic wipe_reg;
    logic done_reg;
    logic save_reg;
    logic int_reg;
    // Sequencer state.
    sisq_state_type state_reg;
    sisq_state_type state_next;

    // Event wires.
    logic             wret_rise;
    logic             wret_fall;
    logic             busy_fall;
    logic             colour_change;
    logic             start_del;
    logic             idle_start;
    logic             setup_busy;
    logic             first_load;
    logic             fixed_load;
    logic             pulse_load;
    logic             first_done;
    logic             fixed_done;
    logic             pulse_busy;
    logic             pulse_done;
    logic             setup_done;
    logic             done_set;
    logic             done_clr;
    logic [CNT_W-1:0] first_count;
    logic [CNT_W-1:0] pulse_count;
    logic [CNT_W-1:0] setup_count;

    // Decode of the start source; the mode field picks the loads.
    function automatic logic start_select(input logic [1:0] mode,
                                          input logic       cmd,
                                          input logic       ldh,
                                          input logic       ldv);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            MODE_NORMAL: hit = 1'b0;
            MODE_HORIZ:  hit = ldh;
            MODE_VERT:   hit = ldv;
            MODE_BOTH:   hit = ldh | ldv;
        endcase
        return hit | cmd;
    endfunction

    // Bit 0 always starts; a load starts only in its own mode or in MODE_BOTH.
    assign start_del = start_select(intensify_mode,
                                    status_write & intensify_cmd,
                                    load_horiz, load_vert); // [R21]
    assign start_delay_strobe = start_del;

    // Edges on the synchronised return lines, read past the first stage.
    assign wret_fall = wret_s3_reg & !wret_s2_reg; // [R14]
    assign wret_rise = !wret_s3_reg & wret_s2_reg; // [R15]
    assign busy_fall = busy_s3_reg & !busy_s2_reg; // [R19]

    // Any flip of the colour bit restarts the setup delay.
    assign colour_change = red_mode ^ red_reg;
    assign colour_change_strobe = colour_change;

    // Red shortens the first settle stage.
    assign first_count = red_mode ? CNT_W'(RED_FIRST_CYC)
                                  : CNT_W'(GREEN_FIRST_CYC); // [R8] [R10]
    // Red or store lengthens the intensify pulse.
    assign pulse_count = (red_mode | store_mode) ? CNT_W'(PULSE_LONG_CYC)
                       : CNT_W'(PULSE_SHORT_CYC); // [R9] [R11] [R13]
    // New colour chooses which setup time runs.
    assign setup_count = red_mode ? CNT_W'(RED_SETUP_CYC)
                                  : CNT_W'(GREEN_SETUP_CYC); // [R4] [R6]

    // Fast mode is sampled at the start, which is why it must be set
    // in an earlier write than the intensify command.
    // A start is taken only when idle and no colour setup is running;
    // without this gate a refused start would still fire the one-shots.
    assign idle_start = (state_reg == SISQ_IDLE) & start_del & !ext_delay
                      & !setup_busy; // [R4]
    assign first_load = idle_start & !fast_intensify; // [R1] [R3]
    assign fixed_load = (idle_start & fast_intensify) | first_done; // [R2]
    assign pulse_load = fixed_done | ((state_reg == SISQ_EXT) & busy_fall);

    // First settle stage.
    sisq_oneshot u_first (
        .clk   (clk),
        .rst   (rst),
        .load  (first_load),
        .count (first_count),
        .busy  (),
        .done  (first_done)
    ); // [R23]

    // Fixed 3us settle stage.
    sisq_oneshot u_fixed (
        .clk   (clk),
        .rst   (rst),
        .load  (fixed_load),
        .count (CNT_W'(FIXED_SETTLE_CYC)),
        .busy  (),
        .done  (fixed_done)
    ); // [R23]

    // Intensify pulse generator.
    sisq_oneshot u_pulse (
        .clk   (clk),
        .rst   (rst),
        .load  (pulse_load),
        .count (pulse_count),
        .busy  (pulse_busy),
        .done  (pulse_done)
    ); // [R23]

    // Colour setup timer; while it runs, a start from idle is refused.
    sisq_oneshot u_setup (
        .clk   (clk),
        .rst   (rst),
        .load  (colour_change),
        .count (setup_count),
        .busy  (setup_busy),
        .done  (setup_done)
    ); // [R4] [R6] [R23]

    // Sequencer next state; requests during colour setup are dropped.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SISQ_IDLE: begin
                if (start_del && !setup_busy) begin
                    if (ext_delay) begin
                        state_next = SISQ_EXT; // [R22]
                    end else if (fast_intensify) begin
                        state_next = SISQ_FIXED; // [R2]
                    end else begin
                        state_next = SISQ_FIRST; // [R1]
                    end
                end
            end
            SISQ_FIRST: begin
                if (first_done) begin
                    state_next = SISQ_FIXED;
                end
            end
            SISQ_FIXED: begin
                if (fixed_done) begin
                    state_next = SISQ_PULSE;
                end
            end
            SISQ_EXT: begin
                if (busy_fall) begin
                    state_next = SISQ_PULSE; // [R22]
                end
            end
            SISQ_PULSE: begin
                if (pulse_done) begin
                    state_next = SISQ_IDLE;
                end
            end
        endcase
    end

    // Done is set at each pulse, setup or wipe end; a start, colour flip or wipe clears it unless a set collides.
    assign done_set = pulse_done | setup_done | wret_rise; // [R5] [R15] [R17]
    assign done_clr = start_del | colour_change | wipe_reg; // [R7] [R18]

    // Synchronisers and flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            wret_s1_reg <= 1'b1;
            wret_s2_reg <= 1'b1;
            wret_s3_reg <= 1'b1;
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            busy_s3_reg <= 1'b0;
            state_reg   <= SISQ_IDLE;
            red_reg     <= 1'b0;
            wipe_reg    <= 1'b0;
            done_reg    <= 1'b1;
            save_reg    <= 1'b0;
            int_reg     <= 1'b0;
        end else begin
            wret_s1_reg <= wipe_return;
            wret_s2_reg <= wret_s1_reg;
            wret_s3_reg <= wret_s2_reg;
            busy_s1_reg <= beam_settling_active;
            busy_s2_reg <= busy_s1_reg;
            busy_s3_reg <= busy_s2_reg;
            state_reg   <= state_next;
            red_reg     <= red_mode;
            // Return low ends the request; a new request wins the tie.
            if (wipe_set) begin
                wipe_reg <= 1'b1; // [R14]
            end else if (wret_fall) begin
                wipe_reg <= 1'b0; // [R14]
            end
            // Set wins over clear so a completion is never lost.
            if (done_set) begin
                done_reg <= 1'b1; // [R16]
            end else if (done_clr) begin
                done_reg <= 1'b0; // [R17]
            end
            if (done_set) begin
                save_reg <= 1'b1; // [R5]
            end
            // Latch interrupt on a rising done; ack clears it.
            if (done_set && !done_reg && int_enable) begin
                int_reg <= 1'b1; // [R16]
            end else if (interrupt_ack) begin
                int_reg <= 1'b0; // [R7]
            end
        end
    end

    // Coordinate latches; init clears them.
    always_ff @(posedge clk) begin
        if (rst || !system_clear_n) begin
            horiz_reg <= '0; // [R20]
            vert_reg  <= '0;
        end else begin
            if (load_horiz) begin
                horiz_reg <= bus_data; // [R20]
            end
            if (load_vert) begin
                vert_reg <= bus_data; // [R20]
            end
        end
    end

    assign horiz_coord   = horiz_reg;
    assign vert_coord    = vert_reg;
    assign intensify_out = pulse_busy;
    assign channel_out   = channel_sel; // [R12]
    assign wipe_request  = wipe_reg; // [R14]
    assign done_flag     = done_reg;
    assign save_latch    = save_reg;
    assign interrupt_req = int_reg;

    // Any fixed stage end, fast or normal, moves to the pulse state with intensify on.
    AST_FAST_SETTLE: assert property (@(posedge clk) disable iff (rst) // [R2]
        (state_reg == SISQ_FIXED) && $rose(fixed_done)
        |=> state_reg == SISQ_PULSE && intensify_out)
        else $error("Fixed stage end did not start intensify.");
    // Start strobe clears done on the next edge unless a set collides.
    AST_START_CLEARS: assert property (@(posedge clk) disable iff (rst) // [R17]
        start_del && !done_set |=> !done_flag)
        else $error("Start strobe did not clear done.");
    // Pulse end sets done.
    AST_PULSE_SETS: assert property (@(posedge clk) disable iff (rst) // [R5]
        pulse_done |=> done_flag && save_latch)
        else $error("Pulse end did not set done.");
    // Interrupt holds until acknowledged.
    AST_INT_HOLD: assert property (@(posedge clk) disable iff (rst) // [R7]
        interrupt_req && !interrupt_ack |=> interrupt_req)
        else $error("Interrupt dropped without ack.");
    // Interrupt rises only with enable.
    AST_INT_CAUSE: assert property (@(posedge clk) disable iff (rst) // [R16]
        $rose(interrupt_req) |-> $past(int_enable) && done_flag)
        else $error("Interrupt without enabled done rise.");
    // Channel follows its bit.
    AST_CHANNEL: assert property (@(posedge clk) disable iff (rst) // [R12]
        channel_out == channel_sel)
        else $error("Channel output differs from bit.");
    // Wipe request holds done low.
    AST_WIPE_DONE: assert property (@(posedge clk) disable iff (rst) // [R18]
        wipe_request && !done_set |=> !done_flag)
        else $error("Done set during wipe.");
    // Horizontal load takes the bus word.
    AST_HLOAD: assert property (@(posedge clk) disable iff (rst) // [R20]
        load_horiz && system_clear_n |=> horiz_coord == $past(bus_data))
        else $error("Horizontal latch missed load.");
    // While a colour setup runs, an idle sequencer stays idle and dark.
    AST_SETUP_BLOCKS: assert property (@(posedge clk) disable iff (rst) // [R4]
        setup_busy && state_reg == SISQ_IDLE
        |=> state_reg == SISQ_IDLE && !intensify_out)
        else $error("Intensify started during colour setup.");
endmodule

// file: pkg/sisq_pkg.sv
// Purpose: Constants for the scope intensify sequencer.
// Assumes: Core clock of 200 MHz; times are kept in nanoseconds.
// Notes:   Cycle counts derive from the times and the clock rate.
package sisq_pkg;
    // Core clock rate in MHz and its period in ns.
    localparam int CLK_MHZ        = 200;
    localparam int CLK_PERIOD_NS  = 5;
    // One-shot times in nanoseconds, as printed.
    localparam int FIXED_SETTLE_NS = 3000;
    localparam int GREEN_FIRST_NS  = 18000;
    localparam int RED_FIRST_NS    = 15000;
    localparam int PULSE_SHORT_NS  = 1000;
    localparam int PULSE_LONG_NS   = 6000;
    localparam int RED_SETUP_NS    = 300000;
    localparam int GREEN_SETUP_NS  = 1600000;
    // Cycle counts; every one rounds to a whole number of cycles.
    localparam int FIXED_SETTLE_CYC = FIXED_SETTLE_NS / CLK_PERIOD_NS;
    localparam int GREEN_FIRST_CYC  = GREEN_FIRST_NS / CLK_PERIOD_NS;
    localparam int RED_FIRST_CYC    = RED_FIRST_NS / CLK_PERIOD_NS;
    localparam int PULSE_SHORT_CYC  = PULSE_SHORT_NS / CLK_PERIOD_NS;
    localparam int PULSE_LONG_CYC   = PULSE_LONG_NS / CLK_PERIOD_NS;
    localparam int RED_SETUP_CYC    = RED_SETUP_NS / CLK_PERIOD_NS;
    localparam int GREEN_SETUP_CYC  = GREEN_SETUP_NS / CLK_PERIOD_NS;
    // Width of every one-shot counter.
    localparam int CNT_W = 20;
    // Coordinate width.
    localparam int COORD_W = 12;
    // Mode field codes.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_HORIZ  = 2'h1;
    localparam logic [1:0] MODE_VERT   = 2'h2;
    localparam logic [1:0] MODE_BOTH   = 2'h3;
    // Sequencer states.
    typedef enum logic [2:0] {
        SISQ_IDLE,
        SISQ_FIRST,
        SISQ_FIXED,
        SISQ_EXT,
        SISQ_PULSE
    } sisq_state_type;
endpackage

// file: hdl/sisq_oneshot.sv
// Purpose: Retriggerable synchronous down-counter one-shot.
// Assumes: Load and count share one clock.
// Notes:   Done pulses for one cycle when the count reaches its end.
`timescale 1ns/100ps
module sisq_oneshot
    import sisq_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    output logic                  busy,
    output logic                  done
);
    // Remaining cycles; zero means idle.
    logic [CNT_W-1:0] cnt_reg;
    logic             done_reg;
    logic [CNT_W-1:0] cnt_next;

    // A load restarts the interval, as a retriggered one-shot would.
    assign cnt_next = load ? count :
                      (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;

    // Counter and end-of-interval pulse.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= !load && (cnt_reg == CNT_W'(1));
        end
    end

    assign busy = (cnt_reg != '0);
    assign done = done_reg;
endmodule

// file: verif/sisq_scope_model.sv
// Purpose: Behavioural scope that answers wipe and external settle requests.
// Assumes: One clock; returns change just after the rising edge.
// Notes:   Wipe return idles high; the settle line idles low.
`timescale 1ns/100ps
module sisq_scope_model #(
    parameter int WIPE_CYC   = 50,
    parameter int SETTLE_CYC = 100
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic wipe_request,
    input  wire logic start_delay_strobe,
    input  wire logic ext_delay,
    output logic      wipe_return,
    output logic      beam_settling_active
);
    int wipe_cnt;   // Cycles left in the wipe cycle.
    int settle_cnt; // Cycles left in the external settle.
    // The return is grounded for the whole wipe and released at its end.
    always @(posedge clk) begin
        if (rst) begin
            wipe_cnt <= 0;
            wipe_return <= 1'b1;
        end else if (wipe_cnt > 0) begin
            wipe_cnt <= wipe_cnt - 1;
            wipe_return <= (wipe_cnt == 1);
        end else if (wipe_request && wipe_return) begin
            wipe_cnt <= WIPE_CYC;
            wipe_return <= 1'b0;
        end
    end
    // In external delay mode the scope times the settle itself.
    always @(posedge clk) begin
        if (rst) begin
            settle_cnt <= 0;
            beam_settling_active <= 1'b0;
        end else if (settle_cnt > 0) begin
            settle_cnt <= settle_cnt - 1;
            beam_settling_active <= (settle_cnt != 1);
        end else if (start_delay_strobe && ext_delay) begin
            settle_cnt <= SETTLE_CYC;
            beam_settling_active <= 1'b1;
        end
    end
endmodule

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the scope intensify sequencer.
// Assumes: Status bits are levels; strobes are one-cycle pulses.
// Notes:   The green setup timer is too long to run; it is only started.
`timescale 1ns/100ps
module tb_top;
    import sisq_pkg::*;
    localparam int SETTLE = 100;  // External settle length in cycles.
    localparam int LIMIT = 90000; // Ceiling on the whole run in cycles.
    logic clk = 0, rst = 1, system_clear_n = 1;
    logic load_horiz = 0, load_vert = 0, status_write = 0;
    logic intensify_cmd = 0, fast_intensify = 0, ext_delay = 0;
    logic int_enable = 0, red_mode = 0, channel_sel = 0, store_mode = 0;
    logic wipe_set = 0, interrupt_ack = 0, wipe_return, beam_settling_active;
    logic [1:0] intensify_mode = 2'h0;
    logic [COORD_W-1:0] bus_data = 12'h000, horiz_coord, vert_coord;
    logic intensify_out, channel_out, wipe_request, done_flag, save_latch;
    logic interrupt_req, start_delay_strobe, colour_change_strobe;
    int n_mismatch = 0, comparisons = 0, cycles = 0, n;
    always #2.5 clk = ~clk;
    sisq_top i_sisq_top (.clk(clk), .rst(rst),
        .system_clear_n(system_clear_n), .bus_data(bus_data),
        .load_horiz(load_horiz), .load_vert(load_vert),
        .status_write(status_write), .intensify_cmd(intensify_cmd),
        .fast_intensify(fast_intensify), .intensify_mode(intensify_mode),
        .ext_delay(ext_delay), .int_enable(int_enable),
        .red_mode(red_mode), .channel_sel(channel_sel),
        .store_mode(store_mode), .wipe_set(wipe_set),
        .wipe_return(wipe_return),
        .beam_settling_active(beam_settling_active),
        .interrupt_ack(interrupt_ack), .horiz_coord(horiz_coord),
        .vert_coord(vert_coord), .intensify_out(intensify_out),
        .channel_out(channel_out), .wipe_request(wipe_request),
        .done_flag(done_flag), .save_latch(save_latch),
        .interrupt_req(interrupt_req),
        .start_delay_strobe(start_delay_strobe),
        .colour_change_strobe(colour_change_strobe));
    sisq_scope_model #(.WIPE_CYC(50), .SETTLE_CYC(SETTLE)) i_sisq_scope_model (
        .clk(clk), .rst(rst), .wipe_request(wipe_request),
        .start_delay_strobe(start_delay_strobe), .ext_delay(ext_delay),
        .wipe_return(wipe_return),
        .beam_settling_active(beam_settling_active));
    // Prints the counts and the verdict, then stops the run.
    task automatic conclude;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // An equal pair of bounds asks for an exact four-state match.
    task automatic chk(input logic [31:0] got, lo, hi);
        comparisons++;
        if ((lo == hi) ? (got !== lo) : (got < lo || got > hi)) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    // Waits c edges and samples once the edge's updates have landed.
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // One-cycle request: {status_write, intensify_cmd, load_horiz, load_vert}.
    task automatic trig(input logic [3:0] v, input logic exp);
        @(posedge clk);
        {status_write, intensify_cmd, load_horiz, load_vert} <= v;
        #1 chk(start_delay_strobe, exp, exp);
        @(posedge clk);
        {status_write, intensify_cmd, load_horiz, load_vert} <= 4'h0;
    endtask
    // Times the settle delay and the pulse, then checks the done flag two cycles after the pulse ends.
    task automatic point(input int dly, input int w);
        int m;
        n = 0;
        m = 0;
        #1;
        while (intensify_out !== 1'b1 && n < 20000) begin
            wait_cyc(1);
            n++;
        end
        chk(n, dly, dly + 10);
        chk(done_flag, 0, 0);
        while (intensify_out === 1'b1 && m < 2000) begin
            wait_cyc(1);
            m++;
        end
        chk(m, w - 1, w + 1);
        wait_cyc(2);
        chk(done_flag, 1, 1);
    endtask
    // A hang is cut short by the cycle ceiling.
    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        wait_cyc(8);
        rst <= 1'b0;
        wait_cyc(1);
        chk(done_flag, 1, 1);
        chk(horiz_coord, 0, 0);
        bus_data <= 12'hABC;
        trig(4'b0010, 1'b0);
        bus_data <= 12'h123;
        trig(4'b0001, 1'b0);
        channel_sel <= 1'b1;
        wait_cyc(1);
        chk(horiz_coord, 12'hABC, 12'hABC);
        chk(vert_coord, 12'h123, 12'h123);
        chk(channel_out, 1, 1);
        system_clear_n <= 1'b0;
        channel_sel <= 1'b0;
        wait_cyc(2);
        chk(vert_coord, 0, 0);
        chk(channel_out, 0, 0);
        system_clear_n <= 1'b1;
        int_enable <= 1'b1;
        trig(4'b1100, 1'b1);
        point(GREEN_FIRST_CYC + FIXED_SETTLE_CYC, PULSE_SHORT_CYC);
        chk(interrupt_req, 1, 1);
        interrupt_ack <= 1'b1;
        wait_cyc(1);
        interrupt_ack <= 1'b0;
        wait_cyc(2);
        chk(interrupt_req, 0, 0);
        store_mode <= 1'b1;
        trig(4'b1100, 1'b1);
        point(GREEN_FIRST_CYC + FIXED_SETTLE_CYC, PULSE_LONG_CYC);
        store_mode <= 1'b0;
        fast_intensify <= 1'b1;
        trig(4'b1000, 1'b0);
        trig(4'b1100, 1'b1);
        point(FIXED_SETTLE_CYC, PULSE_SHORT_CYC);
        for (int m = 0; m < 4; m++) begin
            intensify_mode <= 2'(m);
            trig(4'b1000, 1'b0);
            bus_data <= 12'(m * 273);
            trig(4'b0010, m[0]);
            if (m[0]) point(FIXED_SETTLE_CYC, PULSE_SHORT_CYC);
            trig(4'b0001, m[1]);
            if (m[1]) point(FIXED_SETTLE_CYC, PULSE_SHORT_CYC);
            chk(horiz_coord, 12'(m * 273), 12'(m * 273));
        end
        intensify_mode <= MODE_NORMAL;
        ext_delay <= 1'b1;
        trig(4'b1100, 1'b1);
        point(SETTLE, PULSE_SHORT_CYC);
        ext_delay <= 1'b0;
        interrupt_ack <= 1'b1;
        wait_cyc(1);
        interrupt_ack <= 1'b0;
        wipe_set <= 1'b1;
        wait_cyc(1);
        wipe_set <= 1'b0;
        wait_cyc(1);
        chk(wipe_request, 1, 1);
        chk(done_flag, 0, 0);
        chk(interrupt_req, 0, 0);
        n = 0;
        while (wipe_return !== 1'b0 && n < 20) begin
            wait_cyc(1);
            n++;
        end
        wait_cyc(6);
        chk(wipe_request, 0, 0);
        chk(done_flag, 0, 0);
        while (wipe_return !== 1'b1 && n < 200) begin
            wait_cyc(1);
            n++;
        end
        wait_cyc(6);
        chk(done_flag, 1, 1);
        chk(interrupt_req, 1, 1);
        interrupt_ack <= 1'b1;
        wait_cyc(1);
        interrupt_ack <= 1'b0;
        @(posedge clk);
        red_mode <= 1'b1;
        status_write <= 1'b1;
        #1 chk(colour_change_strobe, 1, 1);
        @(posedge clk);
        status_write <= 1'b0;
        wait_cyc(2);
        chk(done_flag, 0, 0);
        trig(4'b1100, 1'b1);
        n = 4;
        while (done_flag !== 1'b1 && n < RED_SETUP_CYC + 50) begin
            if (intensify_out !== 1'b0) chk(intensify_out, 0, 0);
            wait_cyc(1);
            n++;
        end
        chk(n, RED_SETUP_CYC - 4, RED_SETUP_CYC + 10);
        chk(save_latch, 1, 1);
        wait_cyc(2);
        chk(interrupt_req, 1, 1);
        fast_intensify <= 1'b0;
        trig(4'b1000, 1'b0);
        trig(4'b1100, 1'b1);
        point(RED_FIRST_CYC + FIXED_SETTLE_CYC, PULSE_LONG_CYC);
        @(posedge clk);
        red_mode <= 1'b0;
        #1 chk(colour_change_strobe, 1, 1);
        wait_cyc(2);
        chk(done_flag, 0, 0);
        conclude();
    end
endmodule
